// File: ctp_timer_pair.sv
// Purpose: Cascadable pair of 16-bit synchronous timers on AHB-Lite
// Assumes: Pins synchronous to clk; single word transfers only
// Notes:   Index 0 is the low (even) timer, index 1 the high (odd)
//
// Notes on behaviour
// [RULE_01] Cascade bit set joins pair into 32 bits
// [RULE_02] Cascade clear gives two independent timers
// [RULE_03] Cascaded: odd control register fully ignored
// [RULE_04] Cascaded: even clock/gate, odd flag raised
// [RULE_05] Odd count is upper word, even lower
// [RULE_06] Odd period upper word, even period lower
// [RULE_07] Cascaded 32-bit period match raises interrupt
// [RULE_08] Run bit starts or stops selected timer
// [RULE_09] Idle-stop halts timer during idle mode
// [RULE_10] Gate enable ignored with external clock
// [RULE_11] Prescale codes divide by 256, 64, 8, 1
// [RULE_12] Clock source picks pin edges or clk
// [RULE_13] Unimplemented control bits read zero always
// [RULE_14] Synchronous operation only, no asynchronous counting
// [RULE_15] Only first pair drives converter trigger
// [RULE_16] Only first pair issues DMA requests
// [RULE_17] Only first pair exports count time base
// [RULE_18] Gate falling edge raises timer interrupt
// [RULE_19] Period match clears count, sets flag
// [RULE_20] Gated mode counts only while gate high
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ctp_timer_pair #(
  parameter bit IS_FIRST_PAIR = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic idle_mode,
  input wire logic ext_clock_pin_low,
  input wire logic ext_clock_pin_high,
  output logic [1:0] irq_flags,
  output ctp_pkg::ctp_events_t events,
  output logic [15:0] low_time_base,
  output logic [15:0] high_time_base
);
  import ctp_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0] ctrl_low;
  logic [15:0] ctrl_high;
  logic [15:0] low_count_word;
  logic [15:0] high_count_word;
  logic [15:0] low_period_word;
  logic [15:0] high_period_word;
  ctp_bus_state_t state;
  logic [7:0] addr_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire accept = hsel & htrans[1] & hready;
  wire wr_en = (state == CTP_BUS_WRITE);
  wire wr_ctrl_low = wr_en & (addr_q == `CTP_OFS_CTRL_LOW);
  wire wr_ctrl_high = wr_en & (addr_q == `CTP_OFS_CTRL_HIGH);
  wire wr_cnt_low = wr_en & (addr_q == `CTP_OFS_CNT_LOW);
  wire wr_cnt_high = wr_en & (addr_q == `CTP_OFS_CNT_HIGH);
  wire wr_per_low = wr_en & (addr_q == `CTP_OFS_PER_LOW);
  wire wr_per_high = wr_en & (addr_q == `CTP_OFS_PER_HIGH);
  wire wr_flags = wr_en & (addr_q == `CTP_OFS_FLAGS);
  wire [15:0] wdata = hwdata[15:0];

  // ----------------------------------------------------------------
  // Effective control
  // ----------------------------------------------------------------
  ctp_ctrl_t ctl [2];
  wire casc = ctl[0].cascade; // see [RULE_01] [RULE_02]
  assign ctl[0] = ctp_unpack(ctrl_low);
  assign ctl[1] = ctp_unpack(ctrl_high);

  // ----------------------------------------------------------------
  // Clock input, gate and prescaler per timer
  // ----------------------------------------------------------------
  // Pin stages: s1 only feeds s2, edges come from s2 against s3.
  // Everything runs on clk, so no asynchronous counter exists.
  logic [1:0] pin_in;
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [7:0] pre [2];
  logic [1:0] tick;
  logic [1:0] raw_en;
  logic [1:0] gate_fall;
  logic [1:0] gated;
  assign pin_in = {ext_clock_pin_high, ext_clock_pin_low};

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    wire rise = s2[i] & ~s3[i];
    wire fall = ~s2[i] & s3[i];
    wire halted = ctl[i].idle_stop & idle_mode; // see [RULE_09]
    wire [7:0] term = ctp_term(ctl[i].prescale); // see [RULE_11]
    assign gated[i] = ctl[i].gate_en & ~ctl[i].clk_src; // see [RULE_10]
    // see [RULE_12] [RULE_20] [RULE_14] [RULE_08]
    assign raw_en[i] = ctl[i].run & ~halted &
      (ctl[i].clk_src ? rise : (~gated[i] | s2[i]));
    assign tick[i] = raw_en[i] & (pre[i] == term);
    assign gate_fall[i] = gated[i] & ctl[i].run & fall; // see [RULE_18]

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
        s3[i] <= 1'b0;
      end else begin
        s1[i] <= pin_in[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pre[i] <= 8'h00;
      end else if (!ctl[i].run) begin
        pre[i] <= 8'h00;
      end else if (raw_en[i]) begin
        pre[i] <= (pre[i] == term) ? 8'h00 : pre[i] + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  // see [RULE_05] [RULE_06]
  wire [31:0] full_cnt = {high_count_word, low_count_word};
  wire [31:0] full_per = {high_period_word, low_period_word};
  wire full_match = (full_cnt == full_per);
  wire [31:0] full_next = full_match ? 32'h0000_0000 : full_cnt + 32'h1;
  wire match_low = (low_count_word == low_period_word);
  wire match_high = (high_count_word == high_period_word);
  wire [15:0] low_next = match_low ? 16'h0000 : low_count_word + 16'h1;
  wire [15:0] high_next = match_high ? 16'h0000 : high_count_word + 16'h1;
  // In cascade the odd timer follows the even tick only. see [RULE_03]
  wire step_low = tick[0];
  wire step_high = casc ? tick[0] : tick[1];
  wire [15:0] next_low_count = casc ? full_next[15:0] : low_next;
  wire [15:0] next_high_count = casc ? full_next[31:16] : high_next;
  // see [RULE_19] [RULE_07] [RULE_04]
  wire hit_low = ~casc & tick[0] & match_low;
  wire hit_high = casc ? (tick[0] & full_match) : (tick[1] & match_high);
  wire set_low = hit_low | (~casc & gate_fall[0]);
  wire set_high = hit_high | (casc ? gate_fall[0] : gate_fall[1]);
  wire [1:0] flag_set = {set_high, set_low};
  wire [1:0] flag_clr = wr_flags ? wdata[1:0] : 2'b00;
  // Set wins over a clear in the same cycle
  wire [1:0] next_flags = (irq_flags & ~flag_clr) | flag_set;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_count_word <= `CTP_RST_COUNT;
    end else if (wr_cnt_low) begin
      low_count_word <= wdata;
    end else if (step_low) begin
      low_count_word <= next_low_count;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_count_word <= `CTP_RST_COUNT;
    end else if (wr_cnt_high) begin
      high_count_word <= wdata;
    end else if (step_high) begin
      high_count_word <= next_high_count;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_flags <= 2'b00;
    end else begin
      irq_flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Control and period registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_low <= `CTP_RST_CTRL;
      ctrl_high <= `CTP_RST_CTRL;
      low_period_word <= `CTP_RST_PERIOD;
      high_period_word <= `CTP_RST_PERIOD;
    end else begin
      // see [RULE_13]
      if (wr_ctrl_low) ctrl_low <= wdata & `CTP_MASK_CTRL_LOW;
      if (wr_ctrl_high) ctrl_high <= wdata & `CTP_MASK_CTRL_HIGH;
      if (wr_per_low) low_period_word <= wdata;
      if (wr_per_high) high_period_word <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Consumer outputs
  // ----------------------------------------------------------------
  // Later pairs tie these low. see [RULE_15] [RULE_16] [RULE_17]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      events <= '0;
      low_time_base <= 16'h0000;
      high_time_base <= 16'h0000;
    end else begin
      events.adc_trigger <= IS_FIRST_PAIR & hit_high;
      events.dma_req_low <= IS_FIRST_PAIR & set_low;
      events.dma_req_high <= IS_FIRST_PAIR & set_high;
      low_time_base <= IS_FIRST_PAIR ? low_count_word : 16'h0000;
      high_time_base <= IS_FIRST_PAIR ? high_count_word : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Reads take one wait state so a write in the preceding data
  // phase is always visible to the read that follows it.
  wire [15:0] rd_mux =
    (addr_q == `CTP_OFS_CTRL_LOW) ? ctrl_low :
    (addr_q == `CTP_OFS_CTRL_HIGH) ? ctrl_high :
    (addr_q == `CTP_OFS_CNT_LOW) ? low_count_word :
    (addr_q == `CTP_OFS_CNT_HIGH) ? high_count_word :
    (addr_q == `CTP_OFS_PER_LOW) ? low_period_word :
    (addr_q == `CTP_OFS_PER_HIGH) ? high_period_word :
    (addr_q == `CTP_OFS_FLAGS) ? {14'h0000, irq_flags} : 16'h0000;
  wire ctp_bus_state_t next_state =
    (state == CTP_BUS_READ) ? CTP_BUS_IDLE :
    !accept ? CTP_BUS_IDLE :
    hwrite ? CTP_BUS_WRITE : CTP_BUS_READ;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= CTP_BUS_IDLE;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      hresp <= 1'b0;
      case (state)
        CTP_BUS_READ: begin
          hrdata <= {16'h0000, rd_mux};
          hreadyout <= 1'b1;
        end
        default: begin
          if (accept) begin
            addr_q <= {haddr[7:2], 2'b00};
            hreadyout <= hwrite;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ctrl_reserved_zero;
    (state == CTP_BUS_READ) && (addr_q == `CTP_OFS_CTRL_LOW) |=>
      (hrdata[15:0] & ~`CTP_MASK_CTRL_LOW) == 16'h0000 && hreadyout;
  endproperty
  a_ctrl_reserved_zero: assert property (p_ctrl_reserved_zero) // see [RULE_13]
    else $error("reserved control bits read nonzero");

  property p_stop_holds;
    !ctl[0].run && !wr_cnt_low |=> $stable(low_count_word);
  endproperty
  a_stop_holds: assert property (p_stop_holds) // see [RULE_08]
    else $error("stopped low timer moved");

  property p_idle_holds;
    ctl[1].idle_stop && idle_mode && !casc |-> !tick[1];
  endproperty
  a_idle_holds: assert property (p_idle_holds) // see [RULE_09]
    else $error("high timer ticked in idle");

  property p_match_wrap;
    hit_low && !wr_cnt_low |=> low_count_word == 16'h0000 &&
      irq_flags[`CTP_FLAG_LOW];
  endproperty
  a_match_wrap: assert property (p_match_wrap) // see [RULE_19]
    else $error("low match did not wrap and flag");

  property p_cascade_flag;
    casc && tick[0] && full_match && !wr_cnt_high |=>
      irq_flags[`CTP_FLAG_HIGH] && high_count_word == 16'h0000;
  endproperty
  a_cascade_flag: assert property (p_cascade_flag) // see [RULE_07]
    else $error("cascade match missed");

  property p_cascade_no_low_flag;
    casc |-> !set_low;
  endproperty
  a_cascade_no_low_flag: // see [RULE_04]
    assert property (p_cascade_no_low_flag)
    else $error("low flag set in cascade");

  property p_carry;
    casc && tick[0] && low_count_word == 16'hFFFF && !full_match &&
      !wr_cnt_high |=> high_count_word == $past(high_count_word) + 16'h1;
  endproperty
  a_carry: assert property (p_carry) // see [RULE_05]
    else $error("cascade carry lost");

  property p_prescale;
    tick[0] |-> pre[0] == ctp_term(ctl[0].prescale);
  endproperty
  a_prescale: assert property (p_prescale) // see [RULE_11]
    else $error("tick off prescale terminal");

  property p_ext_edge;
    ctl[0].clk_src && raw_en[0] |-> $past(s2[0]) == 1'b0 && s2[0];
  endproperty
  a_ext_edge: assert property (p_ext_edge) // see [RULE_12]
    else $error("external count without rising edge");

  property p_gate_low_holds;
    gated[0] && !s2[0] |-> !raw_en[0];
  endproperty
  a_gate_low_holds: assert property (p_gate_low_holds) // see [RULE_20]
    else $error("gated timer counted with gate low");

  property p_gate_fall_flag;
    gate_fall[1] && !casc |=> irq_flags[`CTP_FLAG_HIGH];
  endproperty
  a_gate_fall_flag: assert property (p_gate_fall_flag) // see [RULE_18]
    else $error("gate fall did not flag");

  property p_later_pair_quiet;
    !IS_FIRST_PAIR |-> events == '0 && low_time_base == 16'h0000;
  endproperty
  a_later_pair_quiet: assert property (p_later_pair_quiet) // see [RULE_15]
    else $error("later pair drove consumer outputs");

  c_cascade_match: cover property (casc && hit_high);
  c_gate_fall: cover property (gate_fall[0]);
  c_read_after_write: cover property (wr_en ##1 state == CTP_BUS_READ);
  c_set_clear_clash: cover property (|(flag_set & flag_clr));

endmodule // ctp_timer_pair
`default_nettype wire

// File: ctp_cfg.svh
// Purpose: Offsets, field positions, reset values and divider terminals
// Assumes: Included by the timer pair package and testbench
// Notes:   Definitions only
`ifndef CTP_CFG_SVH
`define CTP_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CTP_OFS_CTRL_LOW 8'h00
`define CTP_OFS_CTRL_HIGH 8'h04
`define CTP_OFS_CNT_LOW 8'h08
`define CTP_OFS_CNT_HIGH 8'h0C
`define CTP_OFS_PER_LOW 8'h10
`define CTP_OFS_PER_HIGH 8'h14
`define CTP_OFS_FLAGS 8'h18

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTP_BIT_RUN 15
`define CTP_BIT_IDLE_STOP 13
`define CTP_BIT_GATE 6
`define CTP_BIT_PS_HI 5
`define CTP_BIT_PS_LO 4
`define CTP_BIT_CASCADE 3
`define CTP_BIT_CLK_SRC 1
`define CTP_MASK_CTRL_LOW 16'hA07A
`define CTP_MASK_CTRL_HIGH 16'hA072
`define CTP_FLAG_LOW 0
`define CTP_FLAG_HIGH 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTP_RST_CTRL 16'h0000
`define CTP_RST_COUNT 16'h0000
`define CTP_RST_PERIOD 16'hFFFF

// ----------------------------------------------------------------
// Prescaler terminal counts
// ----------------------------------------------------------------
`define CTP_TERM_DIV1 8'h00
`define CTP_TERM_DIV8 8'h07
`define CTP_TERM_DIV64 8'h3F
`define CTP_TERM_DIV256 8'hFF

`endif

// File: ctp_pkg.sv
// Purpose: Types shared by the timer pair
// Assumes: ctp_cfg.svh gives field positions
// Notes:   Control word unpacked into a struct
`default_nettype none
package ctp_pkg;
  `include "ctp_cfg.svh"

  typedef struct packed {
    logic run;
    logic idle_stop;
    logic gate_en;
    logic [1:0] prescale;
    logic cascade;
    logic clk_src;
  } ctp_ctrl_t;

  typedef enum logic [1:0] {
    CTP_BUS_IDLE = 2'b00,
    CTP_BUS_WRITE = 2'b01,
    CTP_BUS_READ = 2'b10
  } ctp_bus_state_t;

  typedef struct packed {
    logic adc_trigger;
    logic dma_req_low;
    logic dma_req_high;
  } ctp_events_t;

  function automatic ctp_ctrl_t ctp_unpack(input logic [15:0] r);
    ctp_ctrl_t c;
    c.run = r[`CTP_BIT_RUN];
    c.idle_stop = r[`CTP_BIT_IDLE_STOP];
    c.gate_en = r[`CTP_BIT_GATE];
    c.prescale = r[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO];
    c.cascade = r[`CTP_BIT_CASCADE];
    c.clk_src = r[`CTP_BIT_CLK_SRC];
    return c;
  endfunction

  function automatic logic [7:0] ctp_term(input logic [1:0] ps);
    logic [7:0] t;
    case (ps)
      2'b11: t = `CTP_TERM_DIV256;
      2'b10: t = `CTP_TERM_DIV64;
      2'b01: t = `CTP_TERM_DIV8;
      default: t = `CTP_TERM_DIV1;
    endcase
    return t;
  endfunction
endpackage
`default_nettype wire

// File: test_cascadable_timer_pair.sv
// Purpose: Self-checking bench for the cascadable timer pair
// Assumes: Bus hready is the slave's own hreadyout
// Notes:   A second instance, not the first pair, must keep its events quiet
`timescale 1ns/1ns
`default_nettype none
`include "ctp_cfg.svh"
`define CHECK(got, exp) begin check_count++; \
  if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module test_cascadable_timer_pair;
  import ctp_pkg::*;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, idle_mode, pin_low, pin_high;
  logic [31:0] haddr, hwdata, hrdata, hrdata2;
  logic [1:0] htrans, irq_flags, irq2;
  logic [2:0] hsize;
  logic [15:0] tb_low, tb_high, tb_low2, tb_high2;
  logic ready2, resp2, other_seen;
  ctp_events_t events, events2;
  int mismatches, check_count;

  ctp_timer_pair i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .idle_mode(idle_mode), .ext_clock_pin_low(pin_low),
    .ext_clock_pin_high(pin_high), .irq_flags(irq_flags), .events(events),
    .low_time_base(tb_low), .high_time_base(tb_high));
  ctp_timer_pair #(.IS_FIRST_PAIR(1'b0)) i_dut_second (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(ready2),
    .hresp(resp2), .hrdata(hrdata2), .idle_mode(idle_mode),
    .ext_clock_pin_low(pin_low), .ext_clock_pin_high(pin_high),
    .irq_flags(irq2), .events(events2), .low_time_base(tb_low2),
    .high_time_base(tb_high2));

  // ----------------------------------------------------------------
  // Clock and watchers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Sticky, so a single stray pulse anywhere in the run is caught
  always @(posedge clk) begin
    if (rst)
      other_seen <= 1'b0;
    else if (events2 !== 3'b000 || tb_low2 !== 16'h0 || tb_high2 !== 16'h0 ||
             resp2 !== 1'b0 || ready2 !== hreadyout || irq2 !== irq_flags ||
             hrdata2 !== hrdata)
      other_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Bus and wait helpers
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic timed_out;
    mismatches++;
    $display("Error at %0t: wait timed out", $time);
    complete_run();
  endtask

  task automatic xfer(input logic wr_en, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr_en;
    haddr <= {24'h000000, a};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100)
      timed_out();
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100)
      timed_out();
    q = hrdata[15:0];
    `CHECK(hresp, 1'b0)
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    xfer(1'b0, a, 16'h0000, q);
    `CHECK(q, e)
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return events.dma_req_low;
      1: return events.dma_req_high;
      2: return irq_flags[0];
      default: return events.adc_trigger;
    endcase
  endfunction

  task automatic wait_on(input int sel, input int bound, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
    end while (pick(sel) !== 1'b1 && cyc < bound);
    if (cyc >= bound)
      timed_out();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic regs_check;
    rd_check(`CTP_OFS_CTRL_LOW, 16'h0000);
    rd_check(`CTP_OFS_PER_LOW, 16'hFFFF);
    rd_check(`CTP_OFS_PER_HIGH, 16'hFFFF);
    rd_check(`CTP_OFS_CNT_HIGH, 16'h0000);
    wr(`CTP_OFS_CTRL_LOW, 16'hFFFF);
    rd_check(`CTP_OFS_CTRL_LOW, 16'hA07A);
    wr(`CTP_OFS_CTRL_LOW, 16'h0000);
    wr(`CTP_OFS_CTRL_HIGH, 16'hFFFF);
    rd_check(`CTP_OFS_CTRL_HIGH, 16'hA072);
    wr(`CTP_OFS_CTRL_HIGH, 16'h0000);
    wr(8'h1C, 16'hFFFF);
    rd_check(8'h1C, 16'h0000);
  endtask

  task automatic prescale_check;
    int cyc;
    int div [4] = '{1, 8, 64, 256};
    wr(`CTP_OFS_PER_LOW, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      wr(`CTP_OFS_CNT_LOW, 16'h0000);
      wr(`CTP_OFS_CTRL_LOW, 16'h8000 | (16'(i) << 4));
      wait_on(0, 3000, cyc);
      wait_on(0, 3000, cyc);
      `CHECK(cyc, 4 * div[i])
      wr(`CTP_OFS_CTRL_LOW, 16'h0000);
    end
    `CHECK(irq_flags, 2'b01)
    wr(`CTP_OFS_FLAGS, 16'h0003);
    wr(`CTP_OFS_PER_HIGH, 16'h0005);
    wr(`CTP_OFS_CNT_HIGH, 16'h0000);
    wr(`CTP_OFS_CTRL_HIGH, 16'h8000);
    wait_on(1, 50, cyc);
    wait_on(1, 50, cyc);
    `CHECK(cyc, 6)
    wr(`CTP_OFS_CTRL_HIGH, 16'h0000);
    `CHECK(irq_flags, 2'b10)
    wr(`CTP_OFS_FLAGS, 16'h0003);
  endtask

  task automatic cascade_check;
    int cyc;
    // Cascade first, so the odd run bit below runs on its own only between the last two control writes
    wr(`CTP_OFS_CTRL_LOW, 16'h0008);
    wr(`CTP_OFS_CTRL_HIGH, 16'h8000);
    wr(`CTP_OFS_PER_LOW, 16'h0008);
    wr(`CTP_OFS_PER_HIGH, 16'h0001);
    wr(`CTP_OFS_CNT_HIGH, 16'h0000);
    wr(`CTP_OFS_CNT_LOW, 16'h0006);
    wr(`CTP_OFS_CTRL_LOW, 16'h8008);
    repeat (4) @(posedge clk);
    wr(`CTP_OFS_CTRL_LOW, 16'h0008);
    `CHECK(irq_flags, 2'b00)
    rd_check(`CTP_OFS_CNT_HIGH, 16'h0000);
    wr(`CTP_OFS_CNT_LOW, 16'hFFFE);
    wr(`CTP_OFS_CTRL_LOW, 16'h8008);
    repeat (3) @(posedge clk);
    wr(`CTP_OFS_CTRL_LOW, 16'h0008);
    rd_check(`CTP_OFS_CNT_HIGH, 16'h0001);
    `CHECK(tb_high, 16'h0001)
    wr(`CTP_OFS_CTRL_LOW, 16'h8008);
    wait_on(3, 40, cyc);
    `CHECK(irq_flags, 2'b10)
    wr(`CTP_OFS_CTRL_LOW, 16'h0008);
    rd_check(`CTP_OFS_CNT_HIGH, 16'h0000);
    wr(`CTP_OFS_CTRL_LOW, 16'h0000);
    wr(`CTP_OFS_CTRL_HIGH, 16'h0000);
    wr(`CTP_OFS_FLAGS, 16'h0003);
  endtask

  task automatic gate_check;
    int cyc;
    logic [15:0] q;
    wr(`CTP_OFS_PER_LOW, 16'hFFFF);
    wr(`CTP_OFS_CNT_LOW, 16'h0000);
    wr(`CTP_OFS_CTRL_LOW, 16'h8040);
    repeat (10) @(posedge clk);
    rd_check(`CTP_OFS_CNT_LOW, 16'h0000);
    pin_low <= 1'b1;
    repeat (10) @(posedge clk);
    pin_low <= 1'b0;
    wait_on(2, 8, cyc);
    wr(`CTP_OFS_CTRL_LOW, 16'h0000);
    xfer(1'b0, `CTP_OFS_CNT_LOW, 16'h0000, q);
    `CHECK(q >= 16'd8 && q <= 16'd12, 1'b1)
    wr(`CTP_OFS_FLAGS, 16'h0003);
    wr(`CTP_OFS_CNT_LOW, 16'h0000);
    wr(`CTP_OFS_CTRL_LOW, 16'h8042);
    repeat (5) begin
      pin_low <= 1'b1;
      repeat (3) @(posedge clk);
      pin_low <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    wr(`CTP_OFS_CTRL_LOW, 16'h0000);
    rd_check(`CTP_OFS_CNT_LOW, 16'h0005);
    `CHECK(irq_flags, 2'b00)
  endtask

  task automatic idle_check;
    logic [15:0] q;
    wr(`CTP_OFS_CNT_LOW, 16'h0000);
    idle_mode <= 1'b1;
    wr(`CTP_OFS_CTRL_LOW, 16'hA000);
    repeat (10) @(posedge clk);
    wr(`CTP_OFS_CTRL_LOW, 16'h2000);
    rd_check(`CTP_OFS_CNT_LOW, 16'h0000);
    wr(`CTP_OFS_CTRL_LOW, 16'h8000);
    repeat (10) @(posedge clk);
    wr(`CTP_OFS_CTRL_LOW, 16'h0000);
    xfer(1'b0, `CTP_OFS_CNT_LOW, 16'h0000, q);
    `CHECK(q != 16'h0000, 1'b1)
    repeat (5) @(posedge clk);
    rd_check(`CTP_OFS_CNT_LOW, q);
    `CHECK(tb_low, q)
    idle_mode <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    idle_mode = 1'b0;
    pin_low = 1'b0;
    pin_high = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    regs_check();
    prescale_check();
    cascade_check();
    gate_check();
    idle_check();
    `CHECK(other_seen, 1'b0)
    complete_run();
  end
endmodule // test_cascadable_timer_pair
`default_nettype wire
